/* tb/pdm_mic_model.sv */
// Behavioural pair of one-bit microphones sharing one data line.
// Assumes the line has a pull-down, so a released line reads low.
`timescale 1ns/1ns
`default_nettype none
module pdm_mic_model (
    // Link
    input wire logic mic_clk,
    output logic mic_data,
    // Stream levels per microphone
    input wire logic left_level,
    input wire logic right_level
);
    // Left mic drives while the clock is low, right while high; the line is always driven
    assign mic_data = mic_clk ? right_level : left_level;
endmodule
`default_nettype wire

/* tb/pdm_mic_record_frontend_tb.sv */
// Testbench of the PDM record front end: APB master, mic pair, scenario tasks.
// Assumes the design's constants header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pdm_fe_params.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module pdm_mic_record_frontend_tb;
    import pdm_fe_pkg::*;
    localparam int HD = 4;
    localparam logic [31:0] BASE = 32'h0002_4600; // Bias and analog mic power bits stay 0
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, pdn_n = 1'b1, data_w, data_oe, clk_out, clk_oe, sample_valid;
    logic lvl_l = 1'b1, lvl_r = 1'b0, clk_w;
    stereo_s sample_out, got;
    path_e path_mode;
    int bad_count = 0, check_count = 0, cycles = 0;
    // Clock pin seen by the mic: pull-down while undriven
    assign clk_w = clk_oe ? clk_out : 1'b0;
    pdm_mic_record_frontend #(.HALF_DIV(HD)) pdm_mic_record_frontend_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_down_pin_n(pdn_n), .pdm_data_in(data_w),
        .pdm_data_oe(data_oe), .pdm_clock_out(clk_out), .pdm_clock_oe(clk_oe), .sample_out(sample_out),
        .sample_valid(sample_valid), .path_mode(path_mode));
    pdm_mic_model pdm_mic_model_i (.mic_clk(clk_w), .mic_data(data_w), .left_level(lvl_l),
        .right_level(lvl_r));
    // Clock and hang guard
    initial begin
        forever #4 pclk = ~pclk; // Clock never stops while the link runs
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            test_done();
        end
    end
    // One APB transfer; entered just after a rising edge; only the hang guard ends a wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Wait for n finished frames, keep the last
    task automatic frames(input int n);
        int t;
        int lim;
        t = 0;
        lim = 600 * n;
        while (n > 0 && t < lim) begin
            @(posedge pclk);
            t++;
            if (sample_valid === 1'b1) begin
                n--;
                got = sample_out;
            end
        end
        if (n > 0) begin
            bad_count++;
            $display("ERROR %0t: no sample", $time);
        end
    endtask
    task automatic t_reset;
        apb(1'b0, `OFS_CTRL, 32'h0); `CHK(rd, `CTRL_RESET)
        apb(1'b0, `OFS_SENS, 32'h0); `CHK(rd[7:0], `SENS_RESET)
        apb(1'b1, 8'h14, 32'h1); `CHK(err, 1'b1)
        `CHK(clk_oe, 1'b0)
        $display("reset test done");
    endtask
    task automatic t_clock;
        int h;
        apb(1'b1, `OFS_CTRL, BASE | 32'h1);
        repeat (40) @(posedge pclk);
        `CHK(clk_oe, 1'b1)
        `CHK(clk_out, 1'b0)
        `CHK(data_oe, 1'b0)
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        while (clk_out !== 1'b1) @(posedge pclk);
        h = 0;
        while (clk_out === 1'b1 && h < 50) begin
            h++;
            @(posedge pclk);
        end
        `CHK(h, HD)
        $display("clock test done");
    endtask
    // Stereo split and both polarities
    task automatic t_stereo;
        lvl_l <= 1'b1;
        lvl_r <= 1'b0;
        apb(1'b1, `OFS_CTRL, BASE | 32'h1B);
        frames(4); `CHK(got.left, 24'h7FFFFF)
        `CHK(got.right, 24'h800000)
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        apb(1'b1, `OFS_CTRL, BASE | 32'h1F);
        frames(4); `CHK(got.left, 24'h800000)
        `CHK(got.right, 24'h7FFFFF)
        $display("stereo test done");
    endtask
    task automatic t_mono;
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        apb(1'b1, `OFS_CTRL, BASE | 32'hB);
        frames(4); `CHK(got.right, 24'h7FFFFF)
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        apb(1'b1, `OFS_CTRL, BASE | 32'h13);
        frames(4); `CHK(got.left, 24'h800000)
        $display("mono test done");
    endtask
    task automatic t_sens;
        lvl_r <= 1'b1;
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        apb(1'b1, `OFS_SENS, 32'h0); // Written with both channels powered off
        apb(1'b1, `OFS_CTRL, BASE | 32'h1B);
        frames(4); `CHK(got.right, 24'h000000)
        `CHK(got.left, 24'h7FFFFF)
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        apb(1'b1, `OFS_SENS, 32'h80);
        apb(1'b1, `OFS_CTRL, BASE | 32'h1B);
        frames(4); `CHK(got.right, 24'h7FFFFF)
        $display("sensitivity test done");
    endtask
    // Wind filter: attenuation climbs to its ceiling, unity again when off
    task automatic t_wind;
        apb(1'b1, `OFS_CTRL, BASE | 32'h201B); // Ceiling set while the filter is off
        apb(1'b1, `OFS_CTRL, BASE | 32'h211B);
        frames(12); `CHK(got.left, 24'h1FFFFF)
        `CHK(got.right, 24'h1FFFFF)
        apb(1'b0, `OFS_STAT, 32'h0);
        `CHK(rd[8:5], 4'b1010)
        apb(1'b1, `OFS_CTRL, BASE | 32'h201B);
        frames(2); `CHK(got.left, 24'h7FFFFF)
        $display("wind test done");
    endtask
    // DC block at the highest cutoff pulls a full-scale level down
    task automatic t_dc;
        apb(1'b1, `OFS_CTRL, BASE | 32'hFB);
        frames(32); `CHK(got.left > 24'sh000000 && got.left < 24'sh400000, 1'b1)
        $display("dc block test done");
    endtask
    // Route bits {filter power, serial, playback[1:0], record} against status
    task automatic t_path;
        logic [4:0] rt [6] = '{5'b01001, 5'b00010, 5'b00001, 5'b01011, 5'b00100, 5'b10000};
        logic [2:0] ex [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd4};
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `OFS_CTRL, (BASE & ~32'h0007_C000) | (32'(rt[i]) << 14));
            apb(1'b0, `OFS_STAT, 32'h0);
            `CHK(rd[2:0], ex[i])
            `CHK(path_mode, path_e'(ex[i]))
        end
        apb(1'b1, `OFS_CTRL, BASE & ~32'h0007_C000); // Filter power off before routing changes
        $display("path test done");
    endtask
    task automatic t_pdn;
        apb(1'b1, `OFS_CTRL, BASE | 32'h3);
        pdn_n <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK(clk_oe, 1'b0)
        `CHK(data_oe, 1'b0)
        `CHK(clk_out, 1'b0)
        pdn_n <= 1'b1;
        $display("power-down test done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_clock();
        t_stereo();
        t_mono();
        t_sens();
        t_wind();
        t_dc();
        t_path();
        t_pdn();
        test_done();
    end
endmodule
`default_nettype wire

/* verilog/pdm_fe_params.svh */
// Constants of the PDM microphone record front end: offsets, fields, resets, timing.
// Assumes a 125 MHz pclk and a 32-bit APB register bus.
`ifndef PDM_FE_PARAMS_SVH
`define PDM_FE_PARAMS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SENS 8'h04
`define OFS_STAT 8'h08
`define OFS_LEFT 8'h0C
`define OFS_RIGHT 8'h10
// Control register fields
`define B_STREAM 0
`define B_CLK_EN 1
`define B_POL 2
`define B_LPWR 3
`define B_RPWR 4
`define B_DC_EN 5
`define F_DC_CUT 7:6
`define B_WIND_EN 8
`define F_WIND_SENS 11:9
`define F_WIND_ATT 13:12
`define B_REC_ROUTE 14
`define F_PB_ROUTE 16:15
`define B_SER_OUT 17
`define B_PFIL_PWR 18
`define B_FIL_PWR 19
`define CTRL_MASK 32'h00FF_FFFF
`define CTRL_RESET 32'h0002_4620
`define SENS_RESET 8'h80
`define SENS_SHIFT 7
// Timing: pclk and pdm clock periods in ns, pdm clock half-period in pclk cycles
`define CLK_PERIOD_NS 8
`define MIC_CLK_PERIOD_NS 64
`define PDM_HALF_DIV (`MIC_CLK_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define BITS_PER_FRAME 64
`define ONES_SHIFT 18
// DC-block shifts for cutoff codes 00..11
`define DC_K0 4'd11
`define DC_K1 4'd9
`define DC_K2 4'd6
`define DC_K3 4'd5
// Wind detector
`define WIND_LP_SHIFT 4
`define WIND_BASE 33'sh0400000
`define WIND_STEP 33'sh0080000
`endif

/* verilog/pdm_fe_pkg.sv */
// Types of the PDM microphone record front end.
// Assumes nothing beyond the constants header.
`default_nettype none
package pdm_fe_pkg;
    typedef struct packed {
        logic signed [23:0] left;
        logic signed [23:0] right;
    } stereo_s;
    typedef enum logic [2:0] {
        REC1_PB2 = 3'b000,
        REC2_PB1 = 3'b001,
        FILT_BYPASS = 3'b010,
        LOOPBACK = 3'b011,
        OTHER_PATH = 3'b100
    } path_e;
endpackage
`default_nettype wire

/* verilog/pdm_mic_record_frontend.sv */
// PDM microphone record front end: clock out, channel split, decimation, DC block,
// right sensitivity, wind filter, channel pattern and path status, APB registers.
// Assumes a single pclk domain; pin inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "pdm_fe_params.svh"
module pdm_mic_record_frontend
    import pdm_fe_pkg::*;
#(
    parameter int HALF_DIV = `PDM_HALF_DIV
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins
    input wire logic power_down_pin_n,
    input wire logic pdm_data_in,
    output logic pdm_data_oe,
    output logic pdm_clock_out,
    output logic pdm_clock_oe,
    // Sample stream and path status
    output stereo_s sample_out,
    output logic sample_valid,
    output path_e path_mode
);
    localparam logic [5:0] LAST_BIT = 6'(`BITS_PER_FRAME - 1);
    localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);

    logic [31:0] ctrl, next_ctrl;
    logic [7:0] sens, next_sens;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic data_meta, data_sync, pdn_meta, pdn_sync;
    logic [7:0] div, next_div;
    logic mclk, next_mclk;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [6:0] acc_l, acc_r, next_acc_l, next_acc_r;
    logic [6:0] cap_l, cap_r, next_cap_l, next_cap_r;
    logic frame, next_frame;
    logic clk_run, tick, left_phase, next_oe;
    logic signed [23:0] dc_st [2], next_dc [2];
    logic signed [23:0] lp_st [2], next_lp [2];
    logic [1:0] att [2], next_att [2];
    logic signed [23:0] pcm [2], hp [2], wd [2];
    logic signed [23:0] sens_r;
    stereo_s next_out;
    path_e next_path;

    function automatic logic signed [23:0] sat(input logic signed [32:0] v);
        if (v > 33'sh07FFFFF) begin
            sat = 24'sh7FFFFF;
        end else if (v < -33'sh0800000) begin
            sat = -24'sh800000;
        end else begin
            sat = v[23:0];
        end
    endfunction

    // Two-flop synchronisers for the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_meta <= 1'b0;
            data_sync <= 1'b0;
            pdn_meta <= 1'b0;
            pdn_sync <= 1'b0;
        end else begin
            data_meta <= pdm_data_in;
            data_sync <= data_meta;
            pdn_meta <= power_down_pin_n;
            pdn_sync <= pdn_meta;
        end
    end

    // APB decode: answer prepared in setup, one access cycle
    always_comb begin
        next_ctrl = ctrl;
        next_sens = sens;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                `OFS_CTRL: next_prdata = ctrl;
                `OFS_SENS: next_prdata = {24'h000000, sens};
                `OFS_STAT: next_prdata = {23'h000000, att[1], att[0], mclk, pdn_sync, path_mode};
                `OFS_LEFT: next_prdata = {{8{sample_out.left[23]}}, sample_out.left};
                `OFS_RIGHT: next_prdata = {{8{sample_out.right[23]}}, sample_out.right};
                default: next_pslverr = 1'b1;
            endcase
        end else if (psel && penable && pready) begin
            if (pwrite && paddr == `OFS_CTRL) begin
                next_ctrl = pwdata & `CTRL_MASK;
            end
            if (pwrite && paddr == `OFS_SENS) begin
                next_sens = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CTRL_RESET;
            sens <= `SENS_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            sens <= next_sens;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // PDM clock divider, channel split and ones counting
    assign clk_run = ctrl[`B_STREAM] && ctrl[`B_CLK_EN] && pdn_sync;
    assign tick = clk_run && div == HALF_LAST;
    assign left_phase = mclk == ctrl[`B_POL];
    always_comb begin
        next_div = 8'h00;
        next_mclk = 1'b0;
        next_bit_cnt = 6'h00;
        next_acc_l = 7'h00;
        next_acc_r = 7'h00;
        next_cap_l = cap_l;
        next_cap_r = cap_r;
        next_frame = 1'b0;
        next_oe = ctrl[`B_STREAM] && pdn_sync;
        if (clk_run) begin
            next_div = tick ? 8'h00 : div + 8'h01;
            next_mclk = tick ? !mclk : mclk;
            next_bit_cnt = bit_cnt;
            next_acc_l = acc_l + 7'((tick && left_phase) ? data_sync : 1'b0);
            next_acc_r = acc_r + 7'((tick && !left_phase) ? data_sync : 1'b0);
            if (tick && !mclk) begin
                next_bit_cnt = bit_cnt + 6'h01;
                if (bit_cnt == LAST_BIT) begin
                    next_frame = 1'b1;
                    next_cap_l = next_acc_l;
                    next_cap_r = next_acc_r;
                    next_acc_l = 7'h00;
                    next_acc_r = 7'h00;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 8'h00;
            mclk <= 1'b0;
            bit_cnt <= 6'h00;
            acc_l <= 7'h00;
            acc_r <= 7'h00;
            cap_l <= 7'h00;
            cap_r <= 7'h00;
            frame <= 1'b0;
            pdm_clock_oe <= 1'b0;
            pdm_data_oe <= 1'b0;
        end else begin
            div <= next_div;
            mclk <= next_mclk;
            bit_cnt <= next_bit_cnt;
            acc_l <= next_acc_l;
            acc_r <= next_acc_r;
            cap_l <= next_cap_l;
            cap_r <= next_cap_r;
            frame <= next_frame;
            pdm_clock_oe <= next_oe;
            pdm_data_oe <= 1'b0; // Data pin is input only
        end
    end
    assign pdm_clock_out = mclk;

    // Sample chain: decimation, DC block, sensitivity, wind filter, pattern
    always_comb begin
        logic [3:0] k;
        logic signed [32:0] d, thr, mag;
        logic [1:0] amax;
        logic [1:0] on;
        k = `DC_K0;
        d = '0;
        mag = '0;
        unique case (ctrl[`F_DC_CUT])
            2'b00: k = `DC_K0;
            2'b01: k = `DC_K1;
            2'b10: k = `DC_K2;
            2'b11: k = `DC_K3;
        endcase
        amax = ctrl[`F_WIND_ATT];
        thr = `WIND_BASE - 33'(ctrl[`F_WIND_SENS]) * `WIND_STEP;
        on = {ctrl[`B_RPWR], ctrl[`B_LPWR]};
        pcm[0] = sat(33'({cap_l, 18'h00000}) - 33'sh0800000);
        pcm[1] = sat(33'({cap_r, 18'h00000}) - 33'sh0800000);
        sens_r = 24'sh000000;
        for (int i = 0; i < 2; i++) begin
            next_dc[i] = dc_st[i];
            next_lp[i] = lp_st[i];
            next_att[i] = ctrl[`B_WIND_EN] ? att[i] : 2'b00;
            d = 33'(pcm[i]) - 33'(dc_st[i]);
            hp[i] = ctrl[`B_DC_EN] ? sat(d) : pcm[i];
            if (frame && on[i]) begin
                next_dc[i] = sat(33'(dc_st[i]) + (d >>> k));
            end
            wd[i] = hp[i];
            if (i == 1) begin
                sens_r = sat((33'(hp[1]) * $signed({25'h0, sens})) >>> `SENS_SHIFT);
                wd[i] = sens_r;
            end
            mag = 33'(lp_st[i]);
            mag = mag < 0 ? -mag : mag;
            if (frame && on[i] && ctrl[`B_WIND_EN]) begin
                next_lp[i] = sat(33'(lp_st[i]) + ((33'(wd[i]) - 33'(lp_st[i])) >>> `WIND_LP_SHIFT));
                if (mag > thr && att[i] < amax) begin
                    next_att[i] = att[i] + 2'b01;
                end else if ((mag <= thr && att[i] != 2'b00) || att[i] > amax) begin
                    next_att[i] = att[i] - 2'b01;
                end
            end
            wd[i] = wd[i] >>> att[i];
        end
        next_out = sample_out;
        unique case (on)
            2'b00: next_out = '0;
            2'b10: next_out = '{left: wd[1], right: wd[1]};
            2'b01: next_out = '{left: wd[0], right: wd[0]};
            2'b11: next_out = '{left: wd[0], right: wd[1]};
        endcase
        if (!frame) begin
            next_out = sample_out;
        end
        next_path = OTHER_PATH;
        if (ctrl[`F_PB_ROUTE] == 2'b00 && !ctrl[`B_SER_OUT] && !ctrl[`B_PFIL_PWR]) begin
            next_path = FILT_BYPASS;
        end else if (ctrl[`B_REC_ROUTE] && ctrl[`F_PB_ROUTE] == 2'b00 && ctrl[`B_SER_OUT]) begin
            next_path = REC1_PB2;
        end else if (!ctrl[`B_REC_ROUTE] && ctrl[`F_PB_ROUTE] == 2'b01 && !ctrl[`B_SER_OUT]) begin
            next_path = REC2_PB1;
        end else if (ctrl[`B_REC_ROUTE] && ctrl[`F_PB_ROUTE] == 2'b01 && ctrl[`B_SER_OUT]) begin
            next_path = LOOPBACK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                dc_st[i] <= 24'sh000000;
                lp_st[i] <= 24'sh000000;
                att[i] <= 2'b00;
            end
            sample_out <= '0;
            sample_valid <= 1'b0;
            path_mode <= REC1_PB2;
        end else begin
            dc_st <= next_dc;
            lp_st <= next_lp;
            att <= next_att;
            sample_out <= next_out;
            sample_valid <= frame;
            path_mode <= next_path;
        end
    end

    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_left_one;
        tick && left_phase && data_sync && bit_cnt != LAST_BIT;
    endsequence
    a_clk_held_low: assert property (!clk_run |=> !pdm_clock_out)
        else $error("pdm clock not low while disabled");
    a_clk_half_period: assert property ($rose(pdm_clock_out) |-> (pdm_clock_out || !clk_run)[*4])
        else $error("pdm clock high phase too short");
    a_pins_float: assert property (!pdn_sync |=> !pdm_clock_oe && !pdm_data_oe)
        else $error("pins driven in power-down");
    a_left_capture: assert property (s_left_one |=> acc_l == $past(acc_l) + 7'h01)
        else $error("left bit not counted");
    a_full_scale: assert property (cap_l == 7'd64 |-> pcm[0] == 24'sh7FFFFF)
        else $error("full scale mapping wrong");
    a_zero_scale: assert property (cap_r == 7'd0 |-> pcm[1] == 24'sh800000)
        else $error("zero density mapping wrong");
    a_sens_mute: assert property (sens == 8'h00 |-> sens_r == 24'sh000000)
        else $error("sensitivity mute failed");
    a_wind_bypass: assert property (!ctrl[`B_WIND_EN] |=> att[0] == 2'b00 && att[1] == 2'b00)
        else $error("wind attenuation while disabled");
    a_mono_copy: assert property (frame && ctrl[`B_LPWR] != ctrl[`B_RPWR] |=> sample_out.left == sample_out.right)
        else $error("mono copy failed");
    a_zero_out: assert property (frame && !ctrl[`B_LPWR] && !ctrl[`B_RPWR] |=> sample_out == '0)
        else $error("powered-off output not zero");
    a_path_bypass: assert property (ctrl[`F_PB_ROUTE] == 2'b00 && !ctrl[`B_SER_OUT] && !ctrl[`B_PFIL_PWR]
        |=> path_mode == FILT_BYPASS)
        else $error("bypass path not shown");
endmodule
`default_nettype wire
